// File: hdl/sbr_board.sv
// Board end: I/O decode, pointer control, encoders, step clocks
// How it works
// - Control register at offset 0, read/write pointer.
// - Offset 1 reaches the selected controller register.
// - Bit 7 picks channel B step clock source.
// - Bit 6 picks channel A step clock source.
// - Bit 5 gates channel B interrupt.
// - Bit 4 gates channel A interrupt.
// - Gated interrupts ORed; host polls both controllers.
// - Bit 3 picks encoder shown at readback.
// - Select 10 addresses channel A; bit 0 picks on writes; reads keep last pick.
// - Select 01 addresses channel B likewise.
// - Select 00 writes both; host never reads there.
// - Encoders are 24 bits, three read-only bytes.
// - Offsets 3,4,5 give low, middle, high byte.
// - Any write at offset 2 clears encoder A.
// - Write at offset 5 clears encoder B.
// - Bytes are live; host reads while stationary.
// - Host takes 23-bit magnitude, bit 23 negative.
// - Writes at offsets 3 and 4 reset controllers.
// - Host waits 100 us after controller reset.
// - Offsets 6 and 7 hold step clock dividers.
// - Eight locations decoded at switch-set base.
module sbr_board
    import sbr_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // Host I/O bus
    sbr_io_if.dev                  bus,
    // Base address switch, address bits 9..3
    input  wire logic [BASE_W-1:0] i_base_sw,
    // Stepper controllers, index 0 is channel A
    input  wire logic [7:0]        i_ctl_rdata [2],
    input  wire logic [1:0]        i_ctl_irq,
    output logic      [7:0]        o_ctl_wdata,
    output logic                   o_ctl_reg_sel,
    output logic      [1:0]        o_ctl_wr,
    output logic      [1:0]        o_ctl_rd,
    output logic      [1:0]        o_ctl_reset,
    // Encoder count inputs
    input  wire logic [1:0]        i_enc_step,
    input  wire logic [1:0]        i_enc_up,
    // Step clock pins and outputs
    input  wire logic [1:0]        i_ext_clk,
    output logic      [1:0]        o_step_clk
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]        control;
    logic [7:0]        divider [2];
    logic [ENC_W-1:0]  enc_count [2];
    logic [BASE_W-1:0] base_s1, base_s2, base_s3, base_sw;
    logic              iow_q, ior_q;
    logic [7:0]        rd_data;
    logic              irq;
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;

    // ------------------------------------------------------------
    // Address decode and strobe edges
    // ------------------------------------------------------------
    wire       hit      = (bus.addr[9:3] == base_sw);
    wire [2:0] ofs      = bus.addr[2:0];
    wire       wr_evt   = hit & ~bus.iow_n & iow_q;
    wire       rd_evt   = hit & ~bus.ior_n & ior_q;
    wire       rd_act   = hit & ~bus.ior_n;
    wire [1:0] cs       = control[BIT_CHANNEL_SEL_HIGH:BIT_CHANNEL_SEL_LOW];
    wire       enc_sel  = control[BIT_ENC_CHANNEL_SEL];
    wire       ind_wr   = wr_evt & (ofs == OFS_INDIRECT);
    wire       ind_rd   = rd_evt & (ofs == OFS_INDIRECT);

    // Channel targets of the indirect port
    wire       tgt_a_wr = (cs == CS_CHAN_A) | (cs == CS_BOTH_WRITE);
    wire       tgt_b_wr = (cs == CS_CHAN_B) | (cs == CS_BOTH_WRITE);
    wire [1:0] next_wr  = {ind_wr & tgt_b_wr, ind_wr & tgt_a_wr};
    // No controller read strobe when both or neither are selected
    wire [1:0] next_rd  = {ind_rd & (cs == CS_CHAN_B),
                           ind_rd & (cs == CS_CHAN_A)};
    wire [1:0] next_rst = {wr_evt & (ofs == OFS_RST_CTLB),
                           wr_evt & (ofs == OFS_RST_CTLA)};
    wire [1:0] enc_clr  = {wr_evt & (ofs == OFS_CLR_ENCB),
                           wr_evt & (ofs == OFS_CLR_ENCA)};

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    // Live counter, never latched: a moving encoder can tear bytes
    wire [ENC_W-1:0] enc_view = enc_count[enc_sel];
    wire [7:0] ind_view = (cs == CS_CHAN_A) ? i_ctl_rdata[0] :
                          (cs == CS_CHAN_B) ? i_ctl_rdata[1] : READ_UNDEF;
    logic [7:0] next_rd_data;
    always_comb
    begin
        case (ofs)
            OFS_CONTROL:  next_rd_data = control;
            OFS_INDIRECT: next_rd_data = ind_view;
            OFS_ENC_LOW:  next_rd_data = enc_view[7:0];
            OFS_ENC_MID:  next_rd_data = enc_view[15:8];
            OFS_ENC_HIGH: next_rd_data = enc_view[23:16];
            OFS_DIV_A:    next_rd_data = divider[0];
            OFS_DIV_B:    next_rd_data = divider[1];
            default:      next_rd_data = READ_UNDEF;
        endcase
    end

    // Gated interrupts merged onto one request
    wire next_irq = (control[BIT_IRQ_ENABLE_A] & i_ctl_irq[0])
                  | (control[BIT_IRQ_ENABLE_B] & i_ctl_irq[1]);

    // ------------------------------------------------------------
    // Base switch filter: three stages, change taken when 2 and 3 agree
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            base_s1 <= '0;
            base_s2 <= '0;
            base_s3 <= '0;
            base_sw <= '0;
        end
        else
        begin
            base_s1 <= i_base_sw;
            base_s2 <= base_s1;
            base_s3 <= base_s2;
            if (base_s2 == base_s3)
                base_sw <= base_s3;
        end
    end

    // ------------------------------------------------------------
    // Bus registers and strobes
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            iow_q         <= 1'b1;
            ior_q         <= 1'b1;
            control       <= CONTROL_RESET;
            divider[0]    <= DIVIDER_RESET;
            divider[1]    <= DIVIDER_RESET;
            rd_data       <= BUS_IDLE;
            irq           <= 1'b0;
            o_ctl_wdata   <= 8'h00;
            o_ctl_reg_sel <= 1'b0;
            o_ctl_wr      <= 2'h0;
            o_ctl_rd      <= 2'h0;
            o_ctl_reset   <= 2'h0;
        end
        else
        begin
            iow_q       <= bus.iow_n;
            ior_q       <= bus.ior_n;
            irq         <= next_irq;
            o_ctl_wr    <= next_wr;
            o_ctl_rd    <= next_rd;
            o_ctl_reset <= next_rst;
            if (wr_evt && ofs == OFS_CONTROL)
                control <= bus.data;
            if (wr_evt && ofs == OFS_DIV_A)
                divider[0] <= bus.data;
            if (wr_evt && ofs == OFS_DIV_B)
                divider[1] <= bus.data;
            if (ind_wr)
            begin
                o_ctl_wdata   <= bus.data;
                o_ctl_reg_sel <= control[BIT_DATA_OR_STATUS];
            end
            if (rd_act)
                rd_data <= next_rd_data;
        end
    end

    assign bus.dev_data = rd_data;
    assign bus.dev_oe   = rd_act;
    assign bus.irq      = irq;

    // ------------------------------------------------------------
    // 100 kHz base tick shared by both dividers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end
        else
        begin
            tick     <= (tick_cnt == TICK_W'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Per channel: encoder counter, divider, clock source select
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        logic [7:0] div_cnt;
        logic       div_pulse;
        logic       ext_s1, ext_s2, ext_s3, ext_lvl;
        wire        xc = control[BIT_EXT_CLOCK_SEL_A + ch];

        // Clear takes priority over a count in the same cycle
        always_ff @(posedge i_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
                enc_count[ch] <= '0;
            else if (enc_clr[ch])
                enc_count[ch] <= '0;
            else if (i_enc_step[ch])
                enc_count[ch] <= i_enc_up[ch] ? enc_count[ch] + 1'b1
                                              : enc_count[ch] - 1'b1;
        end

        // Divide the base tick by divider+1
        always_ff @(posedge i_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
            begin
                div_cnt   <= 8'h00;
                div_pulse <= 1'b0;
            end
            else
            begin
                div_pulse <= tick && (div_cnt >= divider[ch]);
                if (tick)
                    div_cnt <= (div_cnt >= divider[ch]) ? 8'h00 : div_cnt + 1'b1;
            end
        end

        // External pin filter and source mux
        always_ff @(posedge i_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
            begin
                ext_s1         <= 1'b0;
                ext_s2         <= 1'b0;
                ext_s3         <= 1'b0;
                ext_lvl        <= 1'b0;
                o_step_clk[ch] <= 1'b0;
            end
            else
            begin
                ext_s1 <= i_ext_clk[ch];
                ext_s2 <= ext_s1;
                ext_s3 <= ext_s2;
                if (ext_s2 == ext_s3)
                    ext_lvl <= ext_s3;
                o_step_clk[ch] <= xc ? ext_lvl : div_pulse;
            end
        end
    end
endmodule : sbr_board

// File: hdl/sbr_pkg.sv
// Shared constants for the stepper board register decode
package sbr_pkg;
    // ------------------------------------------------------------
    // Register offsets within the eight-location window
    // ------------------------------------------------------------
    localparam logic [2:0] OFS_CONTROL  = 3'h0;
    localparam logic [2:0] OFS_INDIRECT = 3'h1;
    localparam logic [2:0] OFS_CLR_ENCA = 3'h2;
    localparam logic [2:0] OFS_ENC_LOW  = 3'h3;
    localparam logic [2:0] OFS_ENC_MID  = 3'h4;
    localparam logic [2:0] OFS_ENC_HIGH = 3'h5;
    localparam logic [2:0] OFS_DIV_A    = 3'h6;
    localparam logic [2:0] OFS_DIV_B    = 3'h7;
    localparam logic [2:0] OFS_RST_CTLA = 3'h3;
    localparam logic [2:0] OFS_RST_CTLB = 3'h4;
    localparam logic [2:0] OFS_CLR_ENCB = 3'h5;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_EXT_CLOCK_SEL_B   = 7;
    localparam int BIT_EXT_CLOCK_SEL_A   = 6;
    localparam int BIT_IRQ_ENABLE_B      = 5;
    localparam int BIT_IRQ_ENABLE_A      = 4;
    localparam int BIT_ENC_CHANNEL_SEL   = 3;
    localparam int BIT_CHANNEL_SEL_HIGH  = 2;
    localparam int BIT_CHANNEL_SEL_LOW   = 1;
    localparam int BIT_DATA_OR_STATUS    = 0;
    localparam logic [1:0] CS_CHAN_A     = 2'h2;
    localparam logic [1:0] CS_CHAN_B     = 2'h1;
    localparam logic [1:0] CS_BOTH_WRITE = 2'h0;

    // ------------------------------------------------------------
    // Widths, reset values, bus shape
    // ------------------------------------------------------------
    localparam int ADDR_W   = 10;
    localparam int BASE_W   = 7;
    localparam int ENC_W    = 24;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DIVIDER_RESET = 8'h00;
    localparam logic [7:0] READ_UNDEF    = 8'h00;
    localparam logic [7:0] BUS_IDLE      = 8'hFF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ            = 40_000_000;
    localparam int STEP_BASE_HZ      = 100_000;
    localparam int TICK_CYCLES       = CLK_HZ / STEP_BASE_HZ;
    localparam int TICK_W            = 9;
    localparam int RESET_WAIT_US     = 100;
    localparam int RESET_WAIT_CYCLES =
        (RESET_WAIT_US * (CLK_HZ / 1_000_000) + 0);
    localparam int WAIT_W            = 12;
    localparam int STROBE_CYCLES     = 4;
    localparam int STROBE_W          = 3;
endpackage : sbr_pkg

// File: hdl/sbr_io_if.sv
// Eight-bit I/O bus joining the host end and the board end
interface sbr_io_if;
    logic [9:0] addr;
    logic       ior_n;
    logic       iow_n;
    logic [7:0] host_data;
    logic       host_oe;
    logic [7:0] dev_data;
    logic       dev_oe;
    logic       irq;
    logic [7:0] data;

    // Resolved data wire; an undriven bus floats high
    assign data = dev_oe ? dev_data : (host_oe ? host_data : 8'hFF);

    modport dev  (input addr, ior_n, iow_n, data, output dev_data, dev_oe, irq);
    modport host (output addr, ior_n, iow_n, host_data, host_oe, input data, irq);
endinterface : sbr_io_if

// File: hdl/sbr_host.sv
// Host end: drives single I/O cycles onto the board bus
module sbr_host
    import sbr_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // Board bus
    sbr_io_if.host                 bus,
    // Base address of the board, address bits 9..3
    input  wire logic [BASE_W-1:0] i_base,
    // Request port
    input  wire logic              i_req,
    input  wire logic              i_req_write,
    input  wire logic [2:0]        i_req_offset,
    input  wire logic [7:0]        i_req_wdata,
    output logic                   o_busy,
    output logic                   o_done,
    output logic                   o_refused,
    output logic      [7:0]        o_rdata,
    // Merged board interrupt
    output logic                   o_irq
);
    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_STROBE = 3'b010,
        ST_WAIT   = 3'b100
    } sbr_host_state_t;

    sbr_host_state_t   state;
    logic [2:0]        ofs;
    logic              is_write;
    logic [7:0]        wdata;
    logic [STROBE_W-1:0] strobe_cnt;
    logic [WAIT_W-1:0] wait_cnt;
    logic [1:0]        cs_shadow;

    // Reading the indirect port with both channels selected is illegal
    wire bad_read   = ~i_req_write & (i_req_offset == OFS_INDIRECT)
                    & (cs_shadow == CS_BOTH_WRITE);
    wire take       = (state == ST_IDLE) & i_req;
    wire strobe_end = (state == ST_STROBE) & (strobe_cnt == STROBE_W'(STROBE_CYCLES - 1));
    // Controller reset writes need a settling pause before the next access
    wire ctl_reset  = is_write & ((ofs == OFS_RST_CTLA) | (ofs == OFS_RST_CTLB));
    wire wait_end   = (state == ST_WAIT) & (wait_cnt == WAIT_W'(RESET_WAIT_CYCLES - 1));

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state      <= ST_IDLE;
            ofs        <= 3'h0;
            is_write   <= 1'b0;
            wdata      <= 8'h00;
            strobe_cnt <= '0;
            wait_cnt   <= '0;
            cs_shadow  <= CONTROL_RESET[BIT_CHANNEL_SEL_HIGH:BIT_CHANNEL_SEL_LOW];
            o_done     <= 1'b0;
            o_refused  <= 1'b0;
            o_rdata    <= 8'h00;
        end
        else
        begin
            o_done    <= 1'b0;
            o_refused <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (take && bad_read)
                    begin
                        o_done    <= 1'b1;
                        o_refused <= 1'b1;
                    end
                    else if (take)
                    begin
                        ofs        <= i_req_offset;
                        is_write   <= i_req_write;
                        wdata      <= i_req_wdata;
                        strobe_cnt <= '0;
                        state      <= ST_STROBE;
                    end
                end
                ST_STROBE:
                begin
                    strobe_cnt <= strobe_cnt + 1'b1;
                    if (strobe_end)
                    begin
                        if (!is_write)
                            o_rdata <= bus.data;
                        if (is_write && ofs == OFS_CONTROL)
                            cs_shadow <= wdata[BIT_CHANNEL_SEL_HIGH:BIT_CHANNEL_SEL_LOW];
                        wait_cnt <= '0;
                        if (ctl_reset)
                            state <= ST_WAIT;
                        else
                        begin
                            state  <= ST_IDLE;
                            o_done <= 1'b1;
                        end
                    end
                end
                ST_WAIT:
                begin
                    wait_cnt <= wait_cnt + 1'b1;
                    if (wait_end)
                    begin
                        state  <= ST_IDLE;
                        o_done <= 1'b1;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bus drive
    // ------------------------------------------------------------
    wire active       = (state == ST_STROBE);
    assign bus.addr      = {i_base, ofs};
    assign bus.iow_n     = ~(active & is_write);
    assign bus.ior_n     = ~(active & ~is_write);
    assign bus.host_data = wdata;
    assign bus.host_oe   = active & is_write;
    assign o_busy        = (state != ST_IDLE);
    // One line for both channels; software polls each controller
    assign o_irq         = bus.irq;
endmodule : sbr_host

// File: verif/sbr_io_chk_sva.sv
// Protocol and readback checker for the stepper board I/O bus
module sbr_io_chk
    import sbr_pkg::*;
#(
    parameter logic [BASE_W-1:0] BASE = 7'h30
)(
    // Clock, reset and bus
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic [9:0] addr,
    input wire logic       ior_n,
    input wire logic       iow_n,
    input wire logic [7:0] host_data,
    input wire logic       host_oe,
    input wire logic [7:0] dev_data,
    input wire logic       dev_oe,
    input wire logic       irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------------------
    // Shadow of stored registers, as the board sees writes
    // ----------------------------------------------------
    logic [7:0] shadow [8];
    wire        hit = addr[9:3] == BASE;
    always_ff @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n)
            shadow <= '{default: 8'h00};
        else if (!iow_n && hit)
            shadow[addr[2:0]] <= host_data;
    // ----------------------------------------------------
    // Properties
    // ----------------------------------------------------
    property p_one_strobe; !(!ior_n && !iow_n); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
    property p_wr_width; $fell(iow_n) |-> !iow_n [*4] ##1 iow_n; endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe width");
    property p_rd_width; $fell(ior_n) |-> !ior_n [*4] ##1 ior_n; endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe width");
    // Address and data must not move while the board may still latch them
    property p_wr_hold;
        !iow_n && !$past(iow_n) |-> $stable(addr) && $stable(host_data) && host_oe;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write cycle not held");
    property p_oe_cause; dev_oe |-> !ior_n && hit && !host_oe; endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("board drives unasked");
    property p_rd_answer; !ior_n && hit |-> dev_oe; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("board silent on read");
    property p_ctl_read;
        !ior_n && !$past(ior_n) && hit && addr[2:0] == OFS_CONTROL |-> dev_data == shadow[0];
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control readback");
    property p_div_read;
        !ior_n && !$past(ior_n) && hit && addr[2:1] == 2'h3 |-> dev_data == shadow[addr[2:0]];
    endproperty
    a_div_read: assert property (p_div_read) else $error("divider readback");
    // Main scenarios reached
    c_ctl_write: cover property (!iow_n && hit && addr[2:0] == OFS_CONTROL);
    c_ind_read: cover property (dev_oe && addr[2:0] == OFS_INDIRECT);
    c_irq: cover property ($rose(irq));
endmodule : sbr_io_chk

// File: verif/tb_sbr_board.sv
// Bench joining host end and board end over the I/O bus
module tb_sbr_board
    import sbr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] BASE = 7'h30;
    localparam logic [7:0] WC [5] = '{8'h04, 8'h05, 8'h02, 8'h01, 8'h06};
    localparam logic [1:0] WW [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
    localparam logic [7:0] RC [5] = '{8'h04, 8'h05, 8'h02, 8'h06, 8'h00};
    localparam logic [7:0] RX [5] = '{8'hA5, 8'hA5, 8'h3C, 8'h00, 8'h00};
    localparam logic [1:0] RR [5] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h0};
    // Stimulus and observed signals
    logic       clk, rst_n = 1'b0, req = 1'b0, wr = 1'b0;
    logic       busy, done, refd, irq, rsel, ref_seen;
    logic [2:0] ofs = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, cwdata;
    logic [7:0] crdata [2] = '{8'hA5, 8'h3C};
    logic [1:0] cirq = 2'h0, estep = 2'h0, eup = 2'h0, xclk = 2'h0;
    logic [1:0] sclk, cwr, crd, crst, wr_seen, rd_seen, rst_seen;
    int         miscompares = 0, samples_checked = 0, cycles = 0, last_n, np, busy_n;

    sbr_io_if bus_if ();
    sbr_board u_sbr_board (.i_clk(clk), .i_rst_n(rst_n), .bus(bus_if), .i_base_sw(BASE),
        .i_ctl_rdata(crdata), .i_ctl_irq(cirq), .o_ctl_wdata(cwdata), .o_ctl_reg_sel(rsel),
        .o_ctl_wr(cwr), .o_ctl_rd(crd), .o_ctl_reset(crst), .i_enc_step(estep),
        .i_enc_up(eup), .i_ext_clk(xclk), .o_step_clk(sclk));
    sbr_host u_sbr_host (.i_clk(clk), .i_rst_n(rst_n), .bus(bus_if), .i_base(BASE),
        .i_req(req), .i_req_write(wr), .i_req_offset(ofs), .i_req_wdata(wdata),
        .o_busy(busy), .o_done(done), .o_refused(refd), .o_rdata(rdata), .o_irq(irq));
    sbr_io_chk #(.BASE(BASE)) u_sbr_io_chk (.i_clk(clk), .i_rst_n(rst_n),
        .addr(bus_if.addr), .ior_n(bus_if.ior_n), .iow_n(bus_if.iow_n),
        .host_data(bus_if.host_data), .host_oe(bus_if.host_oe),
        .dev_data(bus_if.dev_data), .dev_oe(bus_if.dev_oe), .irq(bus_if.irq));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Catch one-cycle controller pulses; cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        wr_seen |= cwr;
        rd_seen |= crd;
        rst_seen |= crst;
        if (cycles == 30000)
        begin
            miscompares++;
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One host access; request held until the take edge, then done awaited
    task automatic acc(input logic w, input logic [2:0] o, input logic [7:0] d);
        wr_seen = 2'h0;
        rd_seen = 2'h0;
        rst_seen = 2'h0;
        last_n = 0;
        busy_n = 0;
        req = 1'b1;
        wr = w;
        ofs = o;
        wdata = d;
        @(posedge clk);
        #2 req = 1'b0;
        while (done !== 1'b1 && last_n < 5000)
        begin
            @(posedge clk);
            #2 last_n++;
            busy_n += int'(busy);
        end
        ref_seen = refd;
    endtask : acc

    task automatic rd(input logic [2:0] o, input logic [7:0] e);
        acc(1'b0, o, 8'h00);
        chk(rdata, e);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic finish_test();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    // ----------------------------------------------------
    // Main sequence
    // ----------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        #2 rst_n = 1'b1;
        tick(5);
        rd(OFS_CONTROL, 8'h00);
        rd(OFS_DIV_B, 8'h00);
        acc(1'b1, OFS_DIV_A, 8'h3C);
        acc(1'b1, OFS_DIV_B, 8'hC3);
        acc(1'b1, OFS_CONTROL, 8'h5A);
        rd(OFS_CONTROL, 8'h5A);
        rd(OFS_DIV_A, 8'h3C);
        rd(OFS_DIV_B, 8'hC3);
        $display("registers done");
        for (int i = 0; i < 5; i++)
        begin
            acc(1'b1, OFS_CONTROL, WC[i]);
            acc(1'b1, OFS_INDIRECT, 8'h50 + 8'(i));
            chk({6'h00, wr_seen}, {6'h00, WW[i]});
            if (WW[i] != 2'h0)
                chk(cwdata ^ {7'h00, rsel}, (8'h50 + 8'(i)) ^ {7'h00, WC[i][0]});
        end
        for (int i = 0; i < 5; i++)
        begin
            acc(1'b1, OFS_CONTROL, RC[i]);
            acc(1'b0, OFS_INDIRECT, 8'h00);
            chk({6'h00, rd_seen}, {6'h00, RR[i]});
            chk({7'h00, ref_seen}, {7'h00, RC[i][2:1] == 2'h0});
            if (RC[i][2:1] != 2'h0)
                chk(rdata, RX[i]);
        end
        $display("indirect done");
        eup = 2'h1;
        repeat (3)
        begin
            estep = 2'h3;
            tick(1);
            estep = 2'h0;
            tick(1);
        end
        acc(1'b1, OFS_CONTROL, 8'h00);
        rd(OFS_ENC_LOW, 8'h03);
        rd(OFS_ENC_MID, 8'h00);
        acc(1'b1, OFS_CONTROL, 8'h08);
        rd(OFS_ENC_LOW, 8'hFD);
        rd(OFS_ENC_MID, 8'hFF);
        rd(OFS_ENC_HIGH, 8'hFF);
        chk({7'h00, rdata[7]}, 8'h01);
        acc(1'b1, OFS_CLR_ENCB, 8'hFF);
        rd(OFS_ENC_LOW, 8'h00);
        acc(1'b1, OFS_CONTROL, 8'h00);
        rd(OFS_ENC_LOW, 8'h03);
        acc(1'b1, OFS_CLR_ENCA, 8'h00);
        rd(OFS_ENC_LOW, 8'h00);
        $display("encoders done");
        acc(1'b1, OFS_RST_CTLA, 8'h12);
        chk({6'h00, rst_seen}, 8'h01);
        chk({7'h00, last_n >= RESET_WAIT_CYCLES}, 8'h01);
        chk(8'(last_n - busy_n), 8'h01);
        acc(1'b1, OFS_RST_CTLB, 8'h34);
        chk({6'h00, rst_seen}, 8'h02);
        $display("resets done");
        cirq = 2'h1;
        acc(1'b1, OFS_CONTROL, 8'h10);
        chk({7'h00, irq}, 8'h01);
        acc(1'b1, OFS_CONTROL, 8'h20);
        chk({7'h00, irq}, 8'h00);
        cirq = 2'h2;
        tick(3);
        chk({7'h00, irq}, 8'h01);
        acc(1'b1, OFS_CONTROL, 8'h30);
        chk({7'h00, irq}, 8'h01);
        $display("interrupts done");
        acc(1'b1, OFS_CONTROL, 8'hC0);
        xclk = 2'h2;
        tick(8);
        chk({6'h00, sclk}, 8'h02);
        xclk = 2'h1;
        tick(8);
        chk({6'h00, sclk}, 8'h01);
        acc(1'b1, OFS_DIV_A, 8'h00);
        acc(1'b1, OFS_CONTROL, 8'h00);
        np = 0;
        repeat (800)
        begin
            tick(1);
            np += int'(sclk[0]);
        end
        chk(8'(np), 8'h02);
        $display("step clocks done");
        finish_test();
    end
endmodule : tb_sbr_board
